// ---- include/svss_pkg.sv ----
// svss_pkg: constants for the serial voltage bus slave and start-up block
package svss_pkg;

  // ==========================================================
  // register map (byte addresses on the axi4-lite port)
  localparam logic [3:0] SVSS_OFF_CTRL = 4'h0;
  localparam logic [3:0] SVSS_OFF_STATUS = 4'h4;
  localparam logic [3:0] SVSS_OFF_TARGET = 4'h8;
  localparam logic [3:0] SVSS_OFF_COUNT = 4'hc;
  localparam int SVSS_ADDR_W = 4;

  // ctrl fields and reset value
  localparam int SVSS_CTRL_BUS_EN = 0;
  localparam int SVSS_CTRL_LL_ALLOW = 1;
  localparam logic [1:0] SVSS_CTRL_RESET = 2'h3;

  // axi responses
  localparam logic [1:0] SVSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SVSS_RESP_SLVERR = 2'h2;

  // ==========================================================
  // serial bus fields
  localparam logic [2:0] SVSS_ADDR_PATTERN = 3'h6;
  localparam logic [6:0] SVSS_OFF_CODE_MIN = 7'h7c;
  localparam int SVSS_CODE_W = 7;

  // boot codes for (clock,data) 11,10,01,00: 0.8 V, 0.9 V, 1.0 V, 1.1 V
  localparam logic [27:0] SVSS_BOOT_TABLE = {7'h3c, 7'h34, 7'h2c, 7'h24};
  // fixed-voltage codes for (clock,data) 11,10,01,00: 0.8 V, 1.0 V, 1.2 V, 1.4 V
  localparam logic [27:0] SVSS_VFIX_TABLE = {7'h3c, 7'h2c, 7'h1c, 7'h0c};

  // ==========================================================
  // state encodings, gray along the usual path
  typedef enum logic [1:0] {
    SVSS_SEQ_OFF = 2'h0,
    SVSS_SEQ_SOFT = 2'h1,
    SVSS_SEQ_WAIT_OK = 2'h3,
    SVSS_SEQ_RUN = 2'h2
  } svss_seq_t;

  typedef enum logic [2:0] {
    SVSS_BUS_IDLE = 3'h0,
    SVSS_BUS_ADDR = 3'h1,
    SVSS_BUS_ACK_A = 3'h3,
    SVSS_BUS_DATA = 3'h2,
    SVSS_BUS_ACK_D = 3'h6,
    SVSS_BUS_STOP = 3'h7,
    SVSS_BUS_IGNORE = 3'h5
  } svss_bus_t;

endpackage : svss_pkg

// ---- design/svss_sync.sv ----
// svss_sync: two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module svss_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : svss_sync

// ---- design/svss_top.sv ----
// svss_top: serial voltage bus slave with boot-code start-up and axi4-lite status
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module svss_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [svss_pkg::SVSS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [svss_pkg::SVSS_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // start-up pins
  input wire logic enable_pin,
  input wire logic type_select_line,
  input wire logic cpu_power_ok,
  input wire logic fixed_voltage_n,
  input wire logic in_regulation,
  output logic regulator_power_good,
  // serial voltage bus pins, data line is open drain
  input wire logic serial_vid_clock_line,
  input wire logic serial_vid_data_line,
  output logic serial_vid_data_level,
  output logic serial_vid_data_enable,
  // plane targets toward the regulation loops
  output logic [svss_pkg::SVSS_CODE_W-1:0] core_target_code,
  output logic core_plane_on,
  output logic [svss_pkg::SVSS_CODE_W-1:0] northbridge_plane_code,
  output logic northbridge_plane_on,
  output logic light_load_hint_n
);
  import svss_pkg::*;

  // ==========================================================
  // pin synchronisation and edge detection
  logic [6:0] pins_sync;
  logic en_q, scl_q, sda_q;

  svss_sync #(.WIDTH(7)) u_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d({enable_pin, type_select_line, serial_vid_clock_line, serial_vid_data_line,
        cpu_power_ok, fixed_voltage_n, in_regulation}),
    .q(pins_sync)
  );

  wire en_s = pins_sync[6];
  wire type_s = pins_sync[5];
  wire scl_s = pins_sync[4];
  wire sda_s = pins_sync[3];
  wire pok_s = pins_sync[2];
  wire fixed_s = pins_sync[1];
  wire inreg_s = pins_sync[0];

  // previous levels for edge finding, taken from the synchronised copies
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 1'b0;
      scl_q <= 1'b0;
      sda_q <= 1'b0;
    end else begin
      en_q <= en_s;
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  wire en_rise = en_s & ~en_q;
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det = scl_s & scl_q & ~sda_q & sda_s;

  // ==========================================================
  // start-up sequencer
  svss_seq_t seq, next_seq;
  logic serial_mode;
  logic [1:0] boot_code;
  logic [1:0] ctrl;

  // enable low drops the sequence, bus and plane targets back, acting as the block's soft reset; ctrl and the counters keep their values
  always_comb begin
    next_seq = seq;
    if (!en_s) begin
      next_seq = SVSS_SEQ_OFF;
    end else begin
      unique case (seq)
        SVSS_SEQ_OFF: if (en_rise && !type_s) next_seq = SVSS_SEQ_SOFT;
        SVSS_SEQ_SOFT: if (inreg_s) next_seq = SVSS_SEQ_WAIT_OK;
        SVSS_SEQ_WAIT_OK: if (pok_s) next_seq = SVSS_SEQ_RUN;
        SVSS_SEQ_RUN: if (!pok_s) next_seq = SVSS_SEQ_WAIT_OK;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq <= SVSS_SEQ_OFF;
    end else begin
      seq <= next_seq;
    end
  end

  // mode and boot code caught at the enable rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_mode <= 1'b0;
      boot_code <= 2'h0;
    end else if (!en_s) begin
      serial_mode <= 1'b0;
    end else if (en_rise) begin
      serial_mode <= ~type_s;
      if (!type_s) boot_code <= {scl_s, sda_s};
    end
  end

  // power-good follows regulation only once soft-start is done; plane on/off plays no part
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regulator_power_good <= 1'b0;
    end else begin
      regulator_power_good <= inreg_s && (next_seq == SVSS_SEQ_WAIT_OK || next_seq == SVSS_SEQ_RUN);
    end
  end

  wire run = (seq == SVSS_SEQ_RUN) && pok_s;
  wire bus_en = ctrl[SVSS_CTRL_BUS_EN];

  // ==========================================================
  // serial bus receiver
  svss_bus_t bus, next_bus;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [1:0] addr_sel;
  logic [7:0] data_byte;
  logic ack_on;

  wire addr_ok = (shreg[6:4] == SVSS_ADDR_PATTERN) && !sda_s && bus_en;
  wire last_bit = scl_rise && (bit_cnt == 3'h7);

  always_comb begin
    next_bus = bus;
    if (!run || stop_det) begin
      next_bus = SVSS_BUS_IDLE;
    end else if (start_det) begin
      next_bus = SVSS_BUS_ADDR;
    end else begin
      unique case (bus)
        SVSS_BUS_ADDR: if (last_bit) next_bus = addr_ok ? SVSS_BUS_ACK_A : SVSS_BUS_IGNORE;
        SVSS_BUS_ACK_A: if (scl_fall && ack_on) next_bus = SVSS_BUS_DATA;
        SVSS_BUS_DATA: if (last_bit) next_bus = SVSS_BUS_ACK_D;
        SVSS_BUS_ACK_D: if (scl_fall && ack_on) next_bus = SVSS_BUS_STOP;
        SVSS_BUS_IDLE, SVSS_BUS_STOP, SVSS_BUS_IGNORE: next_bus = bus;
        default: next_bus = SVSS_BUS_IDLE;
      endcase
    end
  end

  wire in_ack = (bus == SVSS_BUS_ACK_A) || (bus == SVSS_BUS_ACK_D);
  wire shifting = (bus == SVSS_BUS_ADDR) || (bus == SVSS_BUS_DATA);

  // shift on clock rise; ack is driven from one falling edge to the next
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus <= SVSS_BUS_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      ack_on <= 1'b0;
    end else begin
      bus <= next_bus;
      if (start_det || !run) bit_cnt <= 3'h0;
      else if (shifting && scl_rise) bit_cnt <= bit_cnt + 3'h1;
      if (shifting && scl_rise) shreg <= {shreg[6:0], sda_s};
      if (next_bus != bus || !in_ack) ack_on <= 1'b0;
      else if (scl_fall) ack_on <= 1'b1;
    end
  end

  // address selection and data byte captured at their last bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_sel <= 2'h0;
      data_byte <= 8'h00;
    end else begin
      if (bus == SVSS_BUS_ADDR && last_bit) addr_sel <= shreg[1:0];
      if (bus == SVSS_BUS_DATA && last_bit) data_byte <= {shreg[6:0], sda_s};
    end
  end

  // open drain: only ever pull low, and never outside a running bus
  assign serial_vid_data_level = 1'b0;
  assign serial_vid_data_enable = ack_on && in_ack && run;

  // ==========================================================
  // plane targets
  logic [6:0] core_code, nb_code;
  logic core_on, nb_on, light_n;

  wire cmd_apply = stop_det && (bus == SVSS_BUS_STOP) && run;
  wire apply_core = cmd_apply && addr_sel[1];
  wire apply_nb = cmd_apply && addr_sel[0];
  wire code_on = data_byte[6:0] < SVSS_OFF_CODE_MIN;
  wire [1:0] boot_pick = en_rise ? {scl_s, sda_s} : boot_code;
  wire [6:0] boot_v = SVSS_BOOT_TABLE[7*boot_pick +: 7];
  wire [6:0] vfix_v = SVSS_VFIX_TABLE[7*{scl_s, sda_s} +: 7];
  wire load_boot = (next_seq == SVSS_SEQ_SOFT) || (next_seq == SVSS_SEQ_WAIT_OK);
  wire fixed_on = !fixed_s && en_s;

  always_ff @(posedge aclk) begin
    if (!aresetn || next_seq == SVSS_SEQ_OFF) begin
      core_code <= 7'h00;
      nb_code <= 7'h00;
      core_on <= 1'b0;
      nb_on <= 1'b0;
      light_n <= 1'b1;
    end else if (load_boot) begin
      core_code <= boot_v;
      nb_code <= boot_v;
      core_on <= 1'b1;
      nb_on <= 1'b1;
      light_n <= 1'b1;
    end else if (cmd_apply) begin
      light_n <= data_byte[7];
      if (apply_core) begin
        core_code <= data_byte[6:0];
        core_on <= code_on;
      end
      if (apply_nb) begin
        nb_code <= data_byte[6:0];
        nb_on <= code_on;
      end
    end
  end

  // outputs: fixed mode overrides the stored targets while the pin is low and enable is high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_target_code <= 7'h00;
      northbridge_plane_code <= 7'h00;
      core_plane_on <= 1'b0;
      northbridge_plane_on <= 1'b0;
      light_load_hint_n <= 1'b1;
    end else begin
      core_target_code <= fixed_on ? vfix_v : core_code;
      northbridge_plane_code <= fixed_on ? vfix_v : nb_code;
      core_plane_on <= fixed_on | core_on;
      northbridge_plane_on <= fixed_on | nb_on;
      light_load_hint_n <= light_n | ~ctrl[SVSS_CTRL_LL_ALLOW];
    end
  end

  // ==========================================================
  // counters: applied commands and refused addresses
  logic [15:0] applied_cnt, refused_cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      applied_cnt <= 16'h0000;
      refused_cnt <= 16'h0000;
    end else begin
      if (cmd_apply) applied_cnt <= applied_cnt + 16'h0001;
      if (next_bus == SVSS_BUS_IGNORE && bus == SVSS_BUS_ADDR) refused_cnt <= refused_cnt + 16'h0001;
    end
  end

  // ==========================================================
  // axi4-lite slave: one outstanding write and one read
  logic aw_held, w_held;
  logic [SVSS_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl = aw_addr == SVSS_OFF_CTRL;
  wire wr_known = wr_ctrl || aw_addr == SVSS_OFF_STATUS || aw_addr == SVSS_OFF_TARGET || aw_addr == SVSS_OFF_COUNT;
  wire [31:0] status_v = {21'h0, bus, fixed_on, ~light_n, regulator_power_good, boot_code, serial_mode, seq};
  wire [31:0] target_v = {16'h0, nb_on, nb_code, core_on, core_code};
  wire rd_known = s_axi_araddr == SVSS_OFF_CTRL || s_axi_araddr == SVSS_OFF_STATUS ||
                  s_axi_araddr == SVSS_OFF_TARGET || s_axi_araddr == SVSS_OFF_COUNT;
  wire [31:0] rd_v = (s_axi_araddr == SVSS_OFF_CTRL) ? {30'h0, ctrl} :
                     (s_axi_araddr == SVSS_OFF_STATUS) ? status_v :
                     (s_axi_araddr == SVSS_OFF_TARGET) ? target_v :
                     (s_axi_araddr == SVSS_OFF_COUNT) ? {refused_cnt, applied_cnt} : 32'h0;

  // address and data may arrive in either order; response once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SVSS_RESP_OKAY;
      ctrl <= SVSS_CTRL_RESET;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? SVSS_RESP_OKAY : SVSS_RESP_SLVERR;
        if (wr_ctrl && w_strb[0]) ctrl <= w_data[1:0];
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= SVSS_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_v;
      s_axi_rresp <= rd_known ? SVSS_RESP_OKAY : SVSS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence bad_addr_s;
    bus == SVSS_BUS_ADDR && last_bit && !addr_ok && run && !start_det && !stop_det;
  endsequence

  // an applied command that enable does not cut short
  sequence stop_seen_s;
    cmd_apply && en_s;
  endsequence

  boot_latch_a: assert property (en_s && en_rise && !type_s |=> serial_mode && boot_code == {$past(scl_s), $past(sda_s)})
    else $error("boot code not captured at enable rise");
  parallel_a: assert property (en_rise && type_s |=> !serial_mode && seq == SVSS_SEQ_OFF)
    else $error("parallel selection entered serial start-up");
  pgood_rise_a: assert property (seq == SVSS_SEQ_SOFT && inreg_s && en_s |=> seq == SVSS_SEQ_WAIT_OK && regulator_power_good)
    else $error("power-good missing after soft-start");
  boot_reload_a: assert property (seq == SVSS_SEQ_RUN && !pok_s && en_s |=> core_code == SVSS_BOOT_TABLE[7*boot_code +: 7] && nb_on)
    else $error("boot code not reloaded on power-ok drop");
  quiet_bus_a: assert property (!run |=> !ack_on && bus == SVSS_BUS_IDLE)
    else $error("bus answered while power-ok low");
  nack_addr_a: assert property (bad_addr_s |=> bus == SVSS_BUS_IGNORE ##1 !serial_vid_data_enable)
    else $error("bad address acknowledged");
  apply_stop_a: assert property (seq == SVSS_SEQ_RUN && $past(seq) == SVSS_SEQ_RUN && $changed(core_code) |-> $past(cmd_apply))
    else $error("target changed without a stop");
  off_code_a: assert property (stop_seen_s ##0 apply_core |=> core_on == ($past(data_byte[6:0]) < SVSS_OFF_CODE_MIN))
    else $error("plane on flag wrong after command");
  fixed_follow_a: assert property (fixed_on |=> core_target_code == SVSS_VFIX_TABLE[7*{$past(scl_s), $past(sda_s)} +: 7])
    else $error("fixed mode target not followed");
  light_flag_a: assert property (cmd_apply && ctrl[SVSS_CTRL_LL_ALLOW] |=> ##1 light_load_hint_n == $past(data_byte[7], 2))
    else $error("light-load flag not applied");
  one_off_pg_a: assert property (seq == SVSS_SEQ_RUN && inreg_s && en_s && pok_s |=> regulator_power_good)
    else $error("power-good dropped while running in regulation");

endmodule : svss_top

// ---- verification/svss_cpu_master.sv ----
// svss_cpu_master: behavioural processor-side master of the serial voltage bus
`timescale 1ns/1ns
module svss_cpu_master (
  // bus wires, data is open drain with a pull-up
  output logic serial_vid_clock_line,
  output logic data_pull,
  input wire logic serial_vid_data_line
);
  // ==========================================================
  // bit timing of the 64 ns link clock
  localparam int HALF = 32;

  // idle bus: clock high and data released
  initial begin
    serial_vid_clock_line = 1'b1;
    data_pull = 1'b0;
  end

  // static levels for boot code and fixed mode; the clock stands still here
  task automatic set_lines(input logic clk_lvl, input logic dat_lvl);
    serial_vid_clock_line = clk_lvl;
    data_pull = !dat_lvl;
  endtask : set_lines

  // one bit: data moves only while the clock is low, read back mid high phase
  task automatic put_bit(input logic b, output logic seen);
    data_pull = !b;
    #HALF;
    serial_vid_clock_line = 1'b1;
    #(HALF/2);
    seen = serial_vid_data_line;
    #(HALF/2);
    serial_vid_clock_line = 1'b0;
  endtask : put_bit

  // a byte msb first, then a released slot for the slave's acknowledge
  task automatic put_byte(input logic [7:0] v, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], s);
    end
    put_bit(1'b1, ack_n);
  endtask : put_byte

  // whole frame; the caller chooses the address byte, good or bad
  task automatic frame(input logic [7:0] abyte, input logic [7:0] dbyte, output logic [1:0] acks);
    serial_vid_clock_line = 1'b1;
    data_pull = 1'b0;
    #HALF;
    data_pull = 1'b1;
    #HALF;
    serial_vid_clock_line = 1'b0;
    put_byte(abyte, acks[1]);
    put_byte(dbyte, acks[0]);
    data_pull = 1'b1;
    #HALF;
    serial_vid_clock_line = 1'b1;
    #HALF;
    data_pull = 1'b0;
    #HALF;
  endtask : frame
endmodule : svss_cpu_master

// ---- verification/svss_top_tb.sv ----
// svss_top_tb: self-checking bench for the serial voltage bus slave
`timescale 1ns/1ns
module svss_top_tb;
  import svss_pkg::*;
  // ==========================================================
  // signals
  typedef struct packed {
    logic [7:0] a; logic [7:0] d; logic [1:0] ack; logic [6:0] core; logic con; logic [6:0] nb; logic non; logic hint;
  } svss_row_t;
  logic aclk, aresetn, enable_pin, type_select_line, cpu_power_ok, fixed_voltage_n, in_regulation;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr, scl, data_pull, regulator_power_good;
  logic [3:0] awa, ara, ws;
  logic [31:0] wd, rd, rdat;
  logic [1:0] bre, rre, resp, acks;
  logic serial_vid_data_level, serial_vid_data_enable, core_plane_on, northbridge_plane_on, light_load_hint_n;
  logic [6:0] core_target_code, northbridge_plane_code;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  wire logic sda_wire;
  // open-drain wire with pull-up, low when either side pulls
  assign sda_wire = ~(data_pull | (serial_vid_data_enable & ~serial_vid_data_level));
  // boot rows {clock, data, code}, last one leaves boot at 1.0 V
  localparam logic [8:0] BOOT [4] = '{{2'b00, 7'h24}, {2'b10, 7'h34}, {2'b11, 7'h3c}, {2'b01, 7'h2c}};
  localparam logic [6:0] FIX [4] = '{7'h0c, 7'h1c, 7'h2c, 7'h3c};
  svss_row_t rows [8] = '{
    {8'hc4, 8'h0c, 2'h0, 7'h0c, 1'b1, 7'h2c, 1'b1, 1'b0}, {8'hc2, 8'hfb, 2'h0, 7'h0c, 1'b1, 7'h7b, 1'b1, 1'b1},
    {8'hc6, 8'h00, 2'h0, 7'h00, 1'b1, 7'h00, 1'b1, 1'b0}, {8'hdc, 8'hfe, 2'h0, 7'h00, 1'b0, 7'h00, 1'b1, 1'b1},
    {8'hc4, 8'h40, 2'h0, 7'h40, 1'b1, 7'h00, 1'b1, 1'b0}, {8'ha4, 8'h11, 2'h3, 7'h40, 1'b1, 7'h00, 1'b1, 1'b0},
    {8'hc5, 8'h11, 2'h3, 7'h40, 1'b1, 7'h00, 1'b1, 1'b0}, {8'hc2, 8'h7f, 2'h0, 7'h40, 1'b1, 7'h00, 1'b0, 1'b0}};

  // ==========================================================
  // design and far-side master
  svss_top svss_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bre), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rre),
    .enable_pin(enable_pin), .type_select_line(type_select_line), .cpu_power_ok(cpu_power_ok),
    .fixed_voltage_n(fixed_voltage_n), .in_regulation(in_regulation), .regulator_power_good(regulator_power_good),
    .serial_vid_clock_line(scl), .serial_vid_data_line(sda_wire), .serial_vid_data_level(serial_vid_data_level),
    .serial_vid_data_enable(serial_vid_data_enable), .core_target_code(core_target_code),
    .core_plane_on(core_plane_on), .northbridge_plane_code(northbridge_plane_code),
    .northbridge_plane_on(northbridge_plane_on), .light_load_hint_n(light_load_hint_n));
  svss_cpu_master svss_cpu_master_i (.serial_vid_clock_line(scl), .data_pull(data_pull),
    .serial_vid_data_line(sda_wire));

  // ==========================================================
  // clock, watchdog and helpers
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // a hang is cut short well above the expected run of some 2000 cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checked %0d, errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ends on a falling edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : cyc

  // handshakes are judged from levels at the falling edge, which hold until the next rise
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; ws <= 4'hf; br <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = awv & awr; w_hs = wv & wr; b_hs = bv & br; r = bre;
      @(posedge aclk);
      if (aw_hs) awv <= 1'b0;
      if (w_hs) wv <= 1'b0;
    end
    br <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    @(posedge aclk);
    arv <= 1'b1; ara <= a; rr <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = arv & arr; r_hs = rv & rr; d = rd; r = rre;
      @(posedge aclk);
      if (ar_hs) arv <= 1'b0;
    end
    rr <= 1'b0;
  endtask : axi_rd

  // ==========================================================
  // main sequence
  initial begin
    aresetn <= 1'b0; enable_pin <= 1'b0; type_select_line <= 1'b0; cpu_power_ok <= 1'b0;
    fixed_voltage_n <= 1'b1; in_regulation <= 1'b0; awv <= 1'b0; awa <= 4'h0; wv <= 1'b0;
    wd <= 32'h0; ws <= 4'h0; br <= 1'b0; arv <= 1'b0; ara <= 4'h0; rr <= 1'b0;
    cyc(1);
    @(posedge aclk) aresetn <= 1'b1;
    cyc(1);
    chk({regulator_power_good, core_plane_on, northbridge_plane_on, light_load_hint_n}, 4'h1);
    // parallel selection at enable rise: the serial start-up must not begin
    @(posedge aclk) type_select_line <= 1'b1;
    enable_pin <= 1'b1;
    cyc(8);
    chk({core_plane_on, northbridge_plane_on, regulator_power_good}, 3'h0);
    @(posedge aclk) type_select_line <= 1'b0;
    // every boot code; enable low in between restarts the sequence
    foreach (BOOT[i]) begin
      @(posedge aclk) enable_pin <= 1'b0;
      in_regulation <= 1'b0;
      svss_cpu_master_i.set_lines(BOOT[i][8], BOOT[i][7]);
      cyc(8);
      chk(core_plane_on, 1'b0);
      @(posedge aclk) enable_pin <= 1'b1;
      cyc(8);
      chk(regulator_power_good, 1'b0);
      chk({core_target_code, northbridge_plane_code, core_plane_on, northbridge_plane_on}, {BOOT[i][6:0], BOOT[i][6:0], 2'b11});
      @(posedge aclk) in_regulation <= 1'b1;
      cyc(8);
      chk(regulator_power_good, 1'b1);
    end
    svss_cpu_master_i.set_lines(1'b1, 1'b1);
    @(posedge aclk) cpu_power_ok <= 1'b1;
    cyc(8);
    // command rows, good and refused frames
    foreach (rows[i]) begin
      svss_cpu_master_i.frame(rows[i].a, rows[i].d, acks);
      cyc(12);
      chk(acks, rows[i].ack);
      chk({core_plane_on, northbridge_plane_on, light_load_hint_n, regulator_power_good}, {rows[i].con, rows[i].non, rows[i].hint, 1'b1});
      if (rows[i].con) chk(core_target_code, rows[i].core);
      if (rows[i].non) chk(northbridge_plane_code, rows[i].nb);
    end
    // register bus, unmapped address among the accesses
    axi_rd(SVSS_OFF_CTRL, rdat, resp);
    chk({resp, rdat[29:0]}, {SVSS_RESP_OKAY, 28'h0, SVSS_CTRL_RESET});
    axi_rd(SVSS_OFF_COUNT, rdat, resp);
    chk(rdat, 32'h00020006);
    axi_rd(SVSS_OFF_TARGET, rdat, resp);
    chk(rdat[7:0], 8'hc0);
    axi_rd(4'h2, rdat, resp);
    chk(resp, SVSS_RESP_SLVERR);
    axi_wr(SVSS_OFF_CTRL, 32'h1, resp);
    cyc(4);
    chk({resp, light_load_hint_n}, {SVSS_RESP_OKAY, 1'b1});
    axi_wr(SVSS_OFF_CTRL, 32'h0, resp);
    svss_cpu_master_i.frame(8'hc4, 8'h20, acks);
    cyc(12);
    chk({acks, core_target_code}, {2'b11, 7'h40});
    axi_wr(SVSS_OFF_CTRL, 32'h3, resp);
    // power-ok drop returns to the boot code and shuts the bus out
    @(posedge aclk) cpu_power_ok <= 1'b0;
    cyc(8);
    chk({core_target_code, northbridge_plane_code, core_plane_on, northbridge_plane_on}, {7'h2c, 7'h2c, 2'b11});
    svss_cpu_master_i.frame(8'hc4, 8'h20, acks);
    cyc(12);
    chk({acks, core_target_code}, {2'b11, 7'h2c});
    // fixed mode follows the live levels while power-ok is low
    @(posedge aclk) fixed_voltage_n <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      svss_cpu_master_i.set_lines(i[1], i[0]);
      cyc(8);
      chk({core_target_code, northbridge_plane_code, core_plane_on, northbridge_plane_on}, {FIX[i], FIX[i], 2'b11});
    end
    // reset again mid-run: outputs hold reset levels at the first edge after release
    @(posedge aclk) aresetn <= 1'b0;
    cyc(1);
    @(posedge aclk) aresetn <= 1'b1;
    cyc(1);
    chk({regulator_power_good, core_plane_on, northbridge_plane_on, light_load_hint_n}, 4'h1);
    give_verdict();
  end
endmodule : svss_top_tb
